/* File: rtl/ocd_pkg.sv */
// Constants and types for the opcode class decoder.
// Assumes instruction words arrive with bit 0 of the documented numbering in bit 31.
package ocd_pkg;
	// Instruction word field positions, as little-endian bit indices.
	localparam int OCD_PRIM_HI = 31;
	localparam int OCD_PRIM_LO = 26;
	localparam int OCD_SEC_HI = 10;
	localparam int OCD_SEC_LO = 1;
	localparam int OCD_OE_BIT = 10;
	localparam int OCD_RC_BIT = 0;
	localparam int OCD_WORD_W = 32;
	localparam int OCD_PRIM_W = 6;
	localparam int OCD_SEC_W = 10;

	// Primary opcodes that carry allocated or special space.
	localparam logic [5:0] OCD_OP_ZERO = 6'h00;
	localparam logic [5:0] OCD_OP_MAC = 6'h04;
	localparam logic [5:0] OCD_OP_XL = 6'h13;
	localparam logic [5:0] OCD_OP_X31 = 6'h1f;
	localparam logic [5:0] OCD_OP_FPS = 6'h3b;
	localparam logic [5:0] OCD_OP_FPD = 6'h3f;
	localparam logic [5:0] OCD_OP_FPLS_LO = 6'h30;
	localparam logic [5:0] OCD_OP_FPLS_HI = 6'h37;

	// Special secondary opcodes.
	localparam logic [9:0] OCD_SEC_TIMEBASE = 10'h173;
	localparam logic [9:0] OCD_SEC_FP_DEFINED = 10'h00c;
	localparam logic [4:0] OCD_SEC_ISEL = 5'h0f;

	// Outcome of one decode.
	typedef enum logic [3:0] {
		OCD_CLASS_EXEC = 4'h1,
		OCD_CLASS_NOP = 4'h2,
		OCD_CLASS_AUX = 4'h4,
		OCD_CLASS_ILLEGAL = 4'h8
	} ocd_class_type;

	localparam ocd_class_type OCD_CLASS_RESET = OCD_CLASS_ILLEGAL;
endpackage

/* File: rtl/ocd_decoder.sv */
// Opcode class decoder: sorts each instruction word into executed, true no-op,
// claimed by the auxiliary processor, or reserved-illegal. Result is registered.
// Assumes the word and the claim input come from logic on the same clock.
`timescale 1ns/1ps
module ocd_decoder (
	// Clock and reset
	input wire logic clock,
	input wire logic rst,
	// Instruction in
	input wire logic instr_valid,
	input wire logic [ocd_pkg::OCD_WORD_W-1:0] instr_word,
	input wire logic aux_claim,
	// Decode result
	output logic dec_valid_r,
	output ocd_pkg::ocd_class_type dec_class_r,
	output logic illegal_r,
	output logic aux_offer_r,
	output logic record_r,
	output logic overflow_en_r
);
	import ocd_pkg::*;

	function automatic logic prim_only_impl(input logic [5:0] p);
		prim_only_impl = (p inside {6'h03, 6'h07, 6'h08, [6'h0a:6'h12], 6'h14, 6'h15,
			[6'h17:6'h1d], [6'h20:6'h2f]});
	endfunction

	function automatic logic xl19_impl(input logic [9:0] s);
		xl19_impl = (s inside {10'h000, 10'h010, 10'h021, 10'h026, 10'h032, 10'h033,
			10'h081, 10'h096, 10'h0c1, 10'h0e1, 10'h101, 10'h121, 10'h1a1, 10'h1c1,
			10'h210});
	endfunction

	function automatic logic x4_impl(input logic [9:0] s);
		x4_impl = (s inside {10'h008, 10'h028, 10'h088, 10'h0a8, 10'h188, 10'h1a8});
	endfunction

	function automatic logic xo4_impl(input logic [8:0] s);
		xo4_impl = (s inside {9'h00c, 9'h02c, 9'h02e, 9'h04c, 9'h06c, 9'h06e, 9'h08c,
			9'h0ac, 9'h0ae, 9'h0cc, 9'h0ec, 9'h0ee, 9'h18c, 9'h1ac, 9'h1ae, 9'h1cc,
			9'h1ec, 9'h1ee});
	endfunction

	function automatic logic xo31_impl(input logic [8:0] s);
		xo31_impl = (s inside {9'h008, 9'h00a, 9'h00b, 9'h028, 9'h04b, 9'h068, 9'h088,
			9'h08a, 9'h0c8, 9'h0ca, 9'h0e8, 9'h0ea, 9'h0eb, 9'h10a, 9'h1cb, 9'h1eb});
	endfunction

	function automatic logic x31_impl(input logic [9:0] s);
		x31_impl = (s inside {10'h000, 10'h004, 10'h013, 10'h014, 10'h016, 10'h017,
			10'h018, 10'h01a, 10'h01c, 10'h020, 10'h036, 10'h037, 10'h03c, 10'h04e,
			10'h053, 10'h056, 10'h057, 10'h077, 10'h07c, 10'h083, 10'h090, 10'h092,
			10'h096, 10'h097, 10'h0a3, 10'h0b7, 10'h0d7, 10'h0f6, 10'h0f7, 10'h106,
			10'h116, 10'h117, 10'h11c, 10'h137, 10'h13c, 10'h143, 10'h153, 10'h157,
			10'h177, 10'h197, 10'h19c, 10'h1b7, 10'h1bc, 10'h1c3, 10'h1c6, 10'h1d6,
			10'h1dc, 10'h1e6, 10'h200, 10'h215, 10'h216, 10'h218, 10'h236, 10'h255,
			10'h256, 10'h295, 10'h296, 10'h2d5, 10'h2f6, 10'h316, 10'h318, 10'h338,
			10'h356, 10'h392, 10'h396, 10'h39a, 10'h3b2, 10'h3ba, 10'h3c6, 10'h3d2,
			10'h3d6, 10'h3e6, 10'h3f6});
	endfunction

	function automatic logic preserved_dead(input logic [9:0] s);
		preserved_dead = (s inside {10'h0d2, 10'h0f2, 10'h172, 10'h132, 10'h253,
			10'h293, 10'h136, 10'h1b6});
	endfunction

	// Field extraction.
	wire logic [5:0] prim = instr_word[OCD_PRIM_HI:OCD_PRIM_LO];
	wire logic [9:0] sec = instr_word[OCD_SEC_HI:OCD_SEC_LO];
	wire logic [8:0] sec9 = sec[8:0];
	wire logic is_zero_word = (instr_word == '0);

	wire logic p0 = (prim == OCD_OP_ZERO);
	wire logic p4 = (prim == OCD_OP_MAC);
	wire logic p19 = (prim == OCD_OP_XL);
	wire logic p31 = (prim == OCD_OP_X31);
	wire logic p59 = (prim == OCD_OP_FPS);
	wire logic p63 = (prim == OCD_OP_FPD);

	// Allocated space.
	wire logic alloc19 = p19 && !sec[4] && sec[2] && sec[1];
	wire logic alloc31_a = !sec[4] && !sec[3] && sec[2] && sec[1];
	wire logic alloc31_b = !sec[4] && (sec[2:0] == 3'h6);
	wire logic alloc31_c = (sec == 10'h156) || (sec == 10'h176) || (sec == 10'h336);
	wire logic alloc31 = p31 && (alloc31_a || alloc31_b || alloc31_c);
	wire logic fp_defined63 = p63 && (sec == OCD_SEC_FP_DEFINED);
	wire logic alloc_fp = (p59 || p63) && !sec[4] && (sec[2:1] == 2'h2) && !fp_defined63;
	wire logic alloc0 = p0 && !is_zero_word;
	wire logic allocated = p4 || alloc19 || alloc31 || alloc_fp || alloc0;

	// Floating point is defined but not in the core, so it may run on the coprocessor.
	wire logic fp_space = p59 || p63 || (prim inside {[OCD_OP_FPLS_LO:OCD_OP_FPLS_HI]});

	// Implemented in the core.
	wire logic xo31_hit = p31 && xo31_impl(sec9);
	wire logic isel_hit = p31 && (sec[4:0] == OCD_SEC_ISEL);
	wire logic timebase_hit = p31 && (sec == OCD_SEC_TIMEBASE);
	wire logic x31_hit = p31 && x31_impl(sec) && !preserved_dead(sec);
	wire logic xo4_hit = p4 && xo4_impl(sec9);
	wire logic x4_hit = p4 && x4_impl(sec);
	wire logic xo_form = xo4_hit || xo31_hit;
	wire logic core_impl = prim_only_impl(prim) || (p19 && xl19_impl(sec)) || x4_hit ||
		xo4_hit || x31_hit || xo31_hit || isel_hit || timebase_hit;
	wire logic res_nop = p31 && (sec[9:8] == 2'h2) && (sec[4:0] == 5'h12);

	// Allocated or floating work the core lacks may be offered outside.
	wire logic offerable = (allocated || fp_space) && !core_impl;
	wire logic take_aux = offerable && aux_claim;

	// Priority: executed, then no-op, then claimed by the coprocessor, else illegal.
	wire ocd_class_type class_nxt = core_impl ? OCD_CLASS_EXEC :
		res_nop ? OCD_CLASS_NOP :
		take_aux ? OCD_CLASS_AUX : OCD_CLASS_ILLEGAL;
	wire logic illegal_nxt = instr_valid && (class_nxt == OCD_CLASS_ILLEGAL);
	wire logic record_nxt = core_impl && instr_word[OCD_RC_BIT];
	wire logic overflow_nxt = xo_form && instr_word[OCD_OE_BIT];

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			dec_valid_r <= 1'b0;
			dec_class_r <= OCD_CLASS_RESET;
			illegal_r <= 1'b0;
			aux_offer_r <= 1'b0;
			record_r <= 1'b0;
			overflow_en_r <= 1'b0;
		end else begin
			dec_valid_r <= instr_valid;
			dec_class_r <= class_nxt;
			illegal_r <= illegal_nxt;
			aux_offer_r <= instr_valid && offerable;
			record_r <= record_nxt;
			overflow_en_r <= overflow_nxt;
		end
	end

	// Checks on the registered result, one cycle after the word.
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	chk_zero_word_illegal: assert property (
		instr_valid && is_zero_word |=> illegal_r && dec_class_r == OCD_CLASS_ILLEGAL)
		else $error("all-zero word not flagged illegal");
	chk_rnop_completes: assert property (
		instr_valid && p31 && sec[9:8] == 2'h2 && sec[4:0] == 5'h12
		|=> dec_class_r == OCD_CLASS_NOP && !illegal_r)
		else $error("reserved no-op not completed as no-op");
	chk_timebase_exec: assert property (
		instr_valid && p31 && sec == 10'h173 |=> dec_class_r == OCD_CLASS_EXEC)
		else $error("time-base read not executed");
	chk_preserved_illegal: assert property (
		instr_valid && p31 && (sec == 10'h0d2 || sec == 10'h1b6 || sec == 10'h253)
		&& !aux_claim |=> illegal_r)
		else $error("preserved opcode not illegal");
	chk_xl_alloc_aux: assert property (
		instr_valid && p19 && !sec[4] && sec[2:1] == 2'h3 && aux_claim
		|=> dec_class_r == OCD_CLASS_AUX)
		else $error("allocated primary 19 opcode not sent to coprocessor");
	chk_exact_alloc: assert property (
		instr_valid && p31 && sec == 10'h336 && aux_claim |=> dec_class_r == OCD_CLASS_AUX)
		else $error("secondary 822 not treated as allocated");
	chk_unclaimed_illegal: assert property (
		instr_valid && p59 && !sec[4] && sec[2:1] == 2'h2 && !aux_claim
		|=> illegal_r ##1 !illegal_r || $past(instr_valid) )
		else $error("unclaimed allocated opcode not illegal");
	chk_mac_exec_oe: assert property (
		instr_valid && p4 && sec9 == 9'h1ee
		|=> dec_class_r == OCD_CLASS_EXEC && overflow_en_r == $past(instr_word[10]))
		else $error("multiply-accumulate not executed with its overflow bit");
	chk_xform_no_oe: assert property (
		instr_valid && p4 && sec == 10'h008 |=> !overflow_en_r && record_r == $past(instr_word[0]))
		else $error("X-form multiply reported wrong variant bits");
	chk_class_onehot: assert property (
		$onehot(dec_class_r) && (illegal_r -> dec_class_r == OCD_CLASS_ILLEGAL))
		else $error("decode class not one-hot or inconsistent with illegal");

	cov_exec: cover property (dec_valid_r && dec_class_r == OCD_CLASS_EXEC);
	cov_nop: cover property (dec_valid_r && dec_class_r == OCD_CLASS_NOP);
	cov_aux: cover property (dec_valid_r && dec_class_r == OCD_CLASS_AUX);
	cov_illegal_after_exec: cover property (
		dec_valid_r && dec_class_r == OCD_CLASS_EXEC ##1 illegal_r);
endmodule

/* File: verification/ocd_aux_model.sv */
// Behavioural auxiliary processor that sits beside the opcode class decoder.
// Assumes the bench tells it, word by word, whether it recognises the offered word.
`timescale 1ns/1ps
module ocd_aux_model (
	// Word seen on the issue side
	input wire logic instr_valid,
	// Bench control of recognition
	input wire logic claim_en,
	// Claim back to the core
	output logic aux_claim
);
	// A claim without a valid word would be meaningless, so the model never raises one.
	assign aux_claim = claim_en & instr_valid;
endmodule

/* File: verification/ocd_decoder_tb.sv */
// Self-checking bench for the opcode class decoder with an auxiliary processor model.
// Assumes a single 50 MHz clock and a registered result one cycle after each word.
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin checks++; if ((got) !== (exp)) begin fail_count++; \
	$display("mismatch %s expected %0h seen %0h", nm, exp, got); end end
module ocd_decoder_tb;
	import ocd_pkg::*;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic instr_valid = 1'b0;
	logic claim_en = 1'b0;
	logic aux_claim;
	logic [31:0] instr_word = 32'h0;
	logic dec_valid_r, illegal_r, aux_offer_r, record_r, overflow_en_r;
	ocd_class_type dec_class_r;
	int fail_count = 0;
	int checks = 0;
	ocd_decoder DUT (.clock(clock), .rst(rst), .instr_valid(instr_valid),
		.instr_word(instr_word), .aux_claim(aux_claim), .dec_valid_r(dec_valid_r),
		.dec_class_r(dec_class_r), .illegal_r(illegal_r), .aux_offer_r(aux_offer_r),
		.record_r(record_r), .overflow_en_r(overflow_en_r));
	ocd_aux_model aux (.instr_valid(instr_valid), .claim_en(claim_en), .aux_claim(aux_claim));
	initial begin
		forever #10 clock = ~clock;
	end
	function automatic logic [31:0] mk(input logic [5:0] p, input logic [9:0] s, input logic rc);
		return {p, 15'h0, s, rc};
	endfunction
	task automatic conclude;
		$display("checks %0d mismatches %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	// One word in, result judged one cycle later; record and overflow only for executed words.
	task automatic run(input logic [31:0] w, input logic c, input ocd_class_type cls,
		input logic ill, input logic off, input logic rec, input logic ovf);
		@(posedge clock);
		instr_valid <= 1'b1;
		instr_word <= w;
		claim_en <= c;
		@(posedge clock);
		#1;
		`CHK("valid", 1'b1, dec_valid_r)
		`CHK("class", cls, dec_class_r)
		`CHK("illegal", ill, illegal_r)
		`CHK("offer", off, aux_offer_r)
		`CHK("record", rec, record_r)
		`CHK("overflow", ovf, overflow_en_r)
	endtask
	task automatic t_reset;
		`CHK("rst valid", 1'b0, dec_valid_r)
		`CHK("rst class", OCD_CLASS_ILLEGAL, dec_class_r)
		`CHK("rst illegal", 1'b0, illegal_r)
		$display("test reset done");
	endtask
	task automatic t_mac;
		run(mk(6'h04, 10'h008, 1'b1), 1'b0, OCD_CLASS_EXEC, 0, 0, 1, 0);
		run(mk(6'h04, 10'h20c, 1'b1), 1'b1, OCD_CLASS_EXEC, 0, 0, 1, 1);
		run(mk(6'h04, 10'h3ee, 1'b0), 1'b0, OCD_CLASS_EXEC, 0, 0, 0, 1);
		run(mk(6'h04, 10'h188, 1'b0), 1'b0, OCD_CLASS_EXEC, 0, 0, 0, 0);
		run(mk(6'h04, 10'h000, 1'b1), 1'b0, OCD_CLASS_ILLEGAL, 1, 1, 0, 0);
		run(mk(6'h04, 10'h000, 1'b1), 1'b1, OCD_CLASS_AUX, 0, 1, 0, 0);
		$display("test mac done");
	endtask
	task automatic t_preserved;
		run(mk(6'h1f, 10'h173, 1'b0), 1'b0, OCD_CLASS_EXEC, 0, 0, 0, 0);
		run(mk(6'h1f, 10'h0d2, 1'b0), 1'b1, OCD_CLASS_ILLEGAL, 1, 0, 0, 0);
		run(mk(6'h1f, 10'h253, 1'b0), 1'b1, OCD_CLASS_ILLEGAL, 1, 0, 0, 0);
		run(mk(6'h1f, 10'h1b6, 1'b0), 1'b0, OCD_CLASS_ILLEGAL, 1, 0, 0, 0);
		$display("test preserved done");
	endtask
	task automatic t_nop;
		run(mk(6'h1f, 10'h212, 1'b0), 1'b0, OCD_CLASS_NOP, 0, 0, 0, 0);
		run(mk(6'h1f, 10'h2f2, 1'b1), 1'b1, OCD_CLASS_NOP, 0, 0, 0, 0);
		$display("test nop done");
	endtask
	task automatic t_alloc;
		run(mk(6'h13, 10'h006, 1'b0), 1'b1, OCD_CLASS_AUX, 0, 1, 0, 0);
		run(mk(6'h1f, 10'h156, 1'b0), 1'b1, OCD_CLASS_AUX, 0, 1, 0, 0);
		run(mk(6'h1f, 10'h336, 1'b0), 1'b0, OCD_CLASS_ILLEGAL, 1, 1, 0, 0);
		run(mk(6'h1f, 10'h006, 1'b0), 1'b1, OCD_CLASS_AUX, 0, 1, 0, 0);
		run(mk(6'h3b, 10'h004, 1'b0), 1'b0, OCD_CLASS_ILLEGAL, 1, 1, 0, 0);
		run(mk(6'h3f, 10'h004, 1'b0), 1'b1, OCD_CLASS_AUX, 0, 1, 0, 0);
		$display("test allocated done");
	endtask
	task automatic t_illegal;
		run(32'h0000_0000, 1'b1, OCD_CLASS_ILLEGAL, 1, 0, 0, 0);
		run(32'h0000_0001, 1'b1, OCD_CLASS_AUX, 0, 1, 0, 0);
		run(mk(6'h01, 10'h000, 1'b0), 1'b1, OCD_CLASS_ILLEGAL, 1, 0, 0, 0);
		@(posedge clock);
		instr_valid <= 1'b0;
		instr_word <= 32'h0;
		@(posedge clock);
		#1;
		`CHK("idle valid", 1'b0, dec_valid_r)
		`CHK("idle illegal", 1'b0, illegal_r)
		$display("test illegal done");
	endtask
	initial begin
		repeat (15) @(posedge clock);
		#1;
		t_reset();
		@(posedge clock);
		rst <= 1'b0;
		t_mac();
		t_preserved();
		t_nop();
		t_alloc();
		t_illegal();
		conclude();
	end
	// The whole sequence needs well under 100 cycles; this limit only catches a hang.
	initial begin
		#(20 * 2000);
		fail_count++;
		conclude();
	end
endmodule
